//--- ppm_cfg.svh
// Offsets, field positions, reset values and timing counts of the pin block
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define PPM_IDX_CTRL        6'h00
`define PPM_IDX_INT         6'h1B
`define PPM_IDX_STRAP       6'h1C
`define PPM_IDX_PHYCTL      6'h1F

// ****************************************
// Field positions
// ****************************************
`define PPM_CTRL_DUPLEX_BIT 8
`define PPM_CTRL_ISO_BIT    10
`define PPM_INT_EN_LSB      8
`define PPM_PHYCTL_POL_BIT  9

// ****************************************
// Reset values and encodings
// ****************************************
`define PPM_RST_CTRL        16'h0000
`define PPM_RST_INT_EN      8'h00
`define PPM_RST_POL         1'h0
`define PPM_MODE_RMII       3'h1

// ****************************************
// Timing
// ****************************************
`define PPM_CLK_PERIOD_NS   10
`define PPM_STRAP_SETTLE_NS 60

`endif

//--- ppm_pkg.sv
// Types shared by the pin function and strap block
package ppm_pkg;

	// Receive side from the internal core
	typedef struct packed {
		logic [3:0] data;
		logic       valid;
		logic       error;
		logic       carrier;
		logic       collision;
	} ppm_rx_t;

	// Transmit side towards the internal core
	typedef struct packed {
		logic       enable;
		logic [3:0] data;
	} ppm_tx_t;

	// Levels caught at reset release
	typedef struct packed {
		logic [2:0] addr;
		logic       duplex;
		logic       isolate;
		logic [2:0] mode;
	} ppm_strap_t;

	// Startup sequence
	typedef enum logic [1:0] {
		PPM_ST_SETTLE = 2'b00,
		PPM_ST_LATCH  = 2'b01,
		PPM_ST_RUN    = 2'b10
	} ppm_state_t;

endpackage : ppm_pkg

//--- ppm_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ns
`default_nettype none

module ppm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Asynchronous levels in, filtered levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ****************************************
	// Per-bit chain
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			logic s1_q;  // Metastability catcher, read only by s2
			logic s2_q;  // Second stage
			logic s3_q;  // Third stage
			logic o_q;   // Accepted level
			logic o_d;

			// Accept a change only once stages two and three agree
			always_comb begin
				o_d = (s2_q == s3_q) ? s3_q : o_q;
			end

			// Registers only
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					o_q  <= 1'b0;
				end else begin
					s1_q <= d[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					o_q  <= o_d;
				end
			end

			assign q[gi] = o_q;
		end
	endgenerate

endmodule : ppm_sync

`default_nettype wire

//--- ppm_pin_mux.sv
// Shared pin functions, strap capture and register access of the transceiver
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_cfg.svh"

module ppm_pin_mux
	import ppm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Reference clock and MAC transmit pins
	input  wire logic        reference_clock_in,
	input  wire logic        transmit_enable_in,
	input  wire logic [3:0]  txd_in,
	// Shared receive and strap pins
	input  wire logic [3:0]  rxd_i,
	output logic      [3:0]  rxd_o,
	output logic      [3:0]  rxd_oe,
	input  wire logic        receive_valid_i,
	output logic             receive_valid_o,
	output logic             receive_valid_oe,
	input  wire logic        receive_error_i,
	output logic             receive_error_o,
	output logic             receive_error_oe,
	input  wire logic        collision_i,
	output logic             collision_o,
	output logic             collision_oe,
	input  wire logic        carrier_i,
	output logic             carrier_o,
	output logic             carrier_oe,
	// Clock outputs to the MAC
	output logic             receive_clock_out,
	output logic             transmit_clock_out,
	// Interrupt pin
	output logic             interrupt_output,
	// Internal core side
	input  wire ppm_rx_t     core_rx,
	input  wire logic [7:0]  core_int_event,
	output ppm_tx_t          core_tx,
	output ppm_strap_t       core_cfg,
	output logic             rmii_mode
);

	localparam int SETTLE_CYC = (`PPM_STRAP_SETTLE_NS + `PPM_CLK_PERIOD_NS - 1)
		/ `PPM_CLK_PERIOD_NS;
	// Control reset word held as a constant so single bits can be picked
	localparam logic [15:0] RST_CTRL = `PPM_RST_CTRL;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [13:0] pin_s;  // Filtered pin levels
	ppm_sync #(.W(14)) u_sync (
		.clk (clk),
		.nrst(nrst),
		.d   ({reference_clock_in, transmit_enable_in, txd_in, rxd_i,
			receive_valid_i, receive_error_i, collision_i, carrier_i}),
		.q   (pin_s)
	);

	logic       ref_s;    // Reference clock level
	logic       transmit_enable_in_s;   // Transmit enable level
	logic [3:0] txd_s;    // Transmit data levels
	logic [3:0] rxd_s;    // Receive data pins read back
	logic       receive_valid_s;   // Receive valid pin read back
	logic       receive_error_s;   // Receive error pin read back
	logic       col_s;    // Collision pin read back
	logic       crs_s;    // Carrier pin read back
	assign {ref_s, transmit_enable_in_s, txd_s, rxd_s, receive_valid_s, receive_error_s, col_s, crs_s} = pin_s;

	// ****************************************
	// Startup and strap capture
	// ****************************************
	ppm_state_t st_q, st_d;           // Startup state
	logic [3:0] cnt_q, cnt_d;         // Settle counter
	ppm_strap_t strap_q, strap_d;     // Levels caught at release

	// Next state of the startup sequence
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		strap_d = strap_q;
		unique case (st_q)
			// Synchronisers need a few cycles to show true levels
			PPM_ST_SETTLE: begin
				if (cnt_q == 4'(SETTLE_CYC)) begin
					st_d = PPM_ST_LATCH;
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end
			PPM_ST_LATCH: begin
				strap_d.addr    = {rxd_s[1], rxd_s[2], rxd_s[3]};
				strap_d.duplex  = rxd_s[0];
				strap_d.isolate = receive_error_s;
				strap_d.mode    = {receive_valid_s, crs_s, col_s};
				st_d            = PPM_ST_RUN;
			end
			PPM_ST_RUN: begin
				st_d = PPM_ST_RUN;
			end
			default: begin
				st_d = PPM_ST_SETTLE;
			end
		endcase
	end

	// Startup registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q    <= PPM_ST_SETTLE;
			cnt_q   <= 4'h0;
			strap_q <= '0;
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			strap_q <= strap_d;
		end
	end

	// ****************************************
	// Registers and APB slave
	// ****************************************
	logic        duplex_q, duplex_d;    // Control duplex bit
	logic        iso_q, iso_d;          // Control isolate bit
	logic        pol_q, pol_d;          // Interrupt polarity
	logic [7:0]  int_en_q, int_en_d;    // Interrupt enables
	logic [7:0]  int_st_q, int_st_d;    // Sticky interrupt status
	logic        rdy_q, rdy_d;          // Access answered
	logic        err_q, err_d;          // Unmapped access
	logic [31:0] rdat_q, rdat_d;        // Read data
	logic [5:0]  idx;                   // Word index of the access
	logic        hit;                   // Index maps to a register
	logic        done;                  // Transfer completes this edge
	logic [31:0] rmux;                  // Read value

	assign idx  = paddr[7:2];
	assign done = psel & penable & rdy_q;

	// Address decode and read mux
	always_comb begin
		hit  = 1'b1;
		rmux = 32'h0000_0000;
		unique case (idx)
			`PPM_IDX_CTRL: begin
				rmux[`PPM_CTRL_DUPLEX_BIT] = duplex_q;
				rmux[`PPM_CTRL_ISO_BIT]    = iso_q;
			end
			`PPM_IDX_INT: begin
				rmux[15:0] = {int_en_q, int_st_q};
			end
			`PPM_IDX_STRAP: begin
				rmux[7:0] = strap_q;
			end
			`PPM_IDX_PHYCTL: begin
				rmux[`PPM_PHYCTL_POL_BIT] = pol_q;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Next register values; one wait state before pready
	always_comb begin
		duplex_d = duplex_q;
		iso_d    = iso_q;
		pol_d    = pol_q;
		int_en_d = int_en_q;
		int_st_d = int_st_q;
		rdy_d    = psel & penable & ~rdy_q;
		err_d    = psel & penable & ~rdy_q & ~hit;
		rdat_d   = (psel & penable & ~rdy_q & ~pwrite) ? rmux : 32'h0000_0000;
		if (st_q == PPM_ST_LATCH) begin
			duplex_d = strap_d.duplex;
			iso_d    = strap_d.isolate;
		end
		if (done & pwrite) begin
			unique case (idx)
				`PPM_IDX_CTRL: begin
					duplex_d = pwdata[`PPM_CTRL_DUPLEX_BIT];
					iso_d    = pwdata[`PPM_CTRL_ISO_BIT];
				end
				`PPM_IDX_INT: begin
					int_en_d = pwdata[`PPM_INT_EN_LSB +: 8];
				end
				`PPM_IDX_PHYCTL: begin
					pol_d = pwdata[`PPM_PHYCTL_POL_BIT];
				end
				default: begin
				end
			endcase
		end
		if (done & ~pwrite & (idx == `PPM_IDX_INT)) begin
			int_st_d = 8'h00;
		end
		// A new event wins over the clearing read
		int_st_d = int_st_d | core_int_event;
	end

	// Register file
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			duplex_q <= RST_CTRL[`PPM_CTRL_DUPLEX_BIT];
			iso_q    <= RST_CTRL[`PPM_CTRL_ISO_BIT];
			pol_q    <= `PPM_RST_POL;
			int_en_q <= `PPM_RST_INT_EN;
			int_st_q <= 8'h00;
			rdy_q    <= 1'b0;
			err_q    <= 1'b0;
			rdat_q   <= 32'h0000_0000;
		end else begin
			duplex_q <= duplex_d;
			iso_q    <= iso_d;
			pol_q    <= pol_d;
			int_en_q <= int_en_d;
			int_st_q <= int_st_d;
			rdy_q    <= rdy_d;
			err_q    <= err_d;
			rdat_q   <= rdat_d;
		end
	end

	// ****************************************
	// Pin functions
	// ****************************************
	logic       ref_prev_q;                 // Reference level last cycle
	logic       rise, fall;                 // Reference edges
	logic       rmii;                       // Reduced mode selected
	logic       drive;                      // Pins may be driven
	ppm_rx_t    pin_q, pin_d;               // Receive pin values
	logic [4:0] oe_q, oe_d;                 // Enables: rxd hi, rxd lo, dv, er, col/crs
	ppm_tx_t    tx_q, tx_d;                 // Sampled transmit word
	logic       rclk_q, rclk_d;             // Receive clock out
	logic       tclk_q, tclk_d;             // Transmit clock out
	logic       irq_q, irq_d;               // Interrupt pin level

	assign rise  = ref_s & ~ref_prev_q;
	assign fall  = ~ref_s & ref_prev_q;
	assign rmii  = (strap_q.mode == `PPM_MODE_RMII);
	// nothing driven before straps are held
	assign drive = (st_q == PPM_ST_RUN) & ~iso_q;

	// Next pin state
	always_comb begin
		pin_d  = pin_q;
		tx_d   = tx_q;
		oe_d   = 5'h00;
		rclk_d = 1'b0;
		tclk_d = 1'b0;
		irq_d  = (|(int_st_q & int_en_q)) ^ ~pol_q;
		if (drive) begin
			if (rmii) begin
				oe_d = 5'b0_1110;
				if (fall) begin
					pin_d.data    = {2'b00, core_rx.data[1:0]};
					pin_d.valid   = core_rx.carrier | core_rx.valid;
					pin_d.error   = core_rx.error;
				end
				if (rise) begin
					tx_d = {transmit_enable_in_s, 2'b00, txd_s[1:0]};
				end
			end else begin
				oe_d   = 5'b1_1111;
				rclk_d = ref_s;
				tclk_d = ref_s;
				if (fall) begin
					pin_d = core_rx;
				end
				if (rise) begin
					tx_d = {transmit_enable_in_s, txd_s};
				end
			end
		end else begin
			pin_d = '0;
			tx_d  = '0;
		end
	end

	// Pin registers; the interrupt pin resets high, its inactive level while pol_q is 0
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_prev_q <= 1'b0;
			pin_q      <= '0;
			tx_q       <= '0;
			oe_q       <= 5'h00;
			rclk_q     <= 1'b0;
			tclk_q     <= 1'b0;
			irq_q      <= 1'b1;
		end else begin
			ref_prev_q <= ref_s;
			pin_q      <= pin_d;
			tx_q       <= tx_d;
			oe_q       <= oe_d;
			rclk_q     <= rclk_d;
			tclk_q     <= tclk_d;
			irq_q      <= irq_d;
		end
	end

	// ****************************************
	// Output mapping
	// ****************************************
	logic        rmii_q;                    // Mode flag out
	ppm_strap_t  cfg_q;                     // Live configuration out
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rmii_q <= 1'b0;
			cfg_q  <= '0;
		end else begin
			rmii_q <= rmii;
			cfg_q  <= {strap_q.addr, duplex_q, iso_q, strap_q.mode};
		end
	end

	assign prdata             = rdat_q;
	assign pready             = rdy_q;
	assign pslverr            = err_q;
	assign rxd_o              = pin_q.data;
	assign rxd_oe             = {oe_q[4], oe_q[4], oe_q[3], oe_q[3]};
	assign receive_valid_o    = pin_q.valid;
	assign receive_valid_oe   = oe_q[2];
	assign receive_error_o    = pin_q.error;
	assign receive_error_oe   = oe_q[1];
	assign collision_o        = pin_q.collision;
	assign collision_oe       = oe_q[0];
	assign carrier_o          = pin_q.carrier;
	assign carrier_oe         = oe_q[0];
	assign receive_clock_out  = rclk_q;
	assign transmit_clock_out = tclk_q;
	assign interrupt_output   = irq_q;
	assign core_tx            = tx_q;
	assign core_cfg           = cfg_q;
	assign rmii_mode          = rmii_q;

endmodule : ppm_pin_mux

`default_nettype wire

//--- ppm_pin_mux_properties.sv
// Checker for the shared pin block
`timescale 1ns/1ns
`default_nettype none
`include "ppm_cfg.svh"

module ppm_pin_mux_properties
	import ppm_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pin drive and mode
	input wire logic [3:0]  rxd_oe,
	input wire logic        receive_valid_oe,
	input wire logic        receive_error_oe,
	input wire logic        collision_oe,
	input wire logic        carrier_oe,
	input wire logic        receive_clock_out,
	input wire logic        transmit_clock_out,
	input wire ppm_tx_t     core_tx,
	input wire ppm_strap_t  core_cfg,
	input wire logic        rmii_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Unmapped index and any pin driven
	logic       bad;
	logic       any_oe;
	logic [3:0] age_q;
	logic [3:0] age_d;
	assign bad = !(paddr[7:2] inside {`PPM_IDX_CTRL, `PPM_IDX_INT,
		`PPM_IDX_STRAP, `PPM_IDX_PHYCTL});
	assign any_oe = |{rxd_oe, receive_valid_oe, receive_error_oe,
		collision_oe, carrier_oe};

	// Edges since reset release, saturating so it never wraps
	always_comb begin
		age_d = age_q;
		if (age_q != 4'hF) begin
			age_d = age_q + 4'h1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			age_q <= 4'h0;
		end else begin
			age_q <= age_d;
		end
	end

	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered next cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held beyond one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access phase");
	a_err_map: assert property (psel && penable && !pready
		|=> pslverr == $past(bad))
		else $error("error flag disagrees with address map");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer cycle");
	a_rmii_undriven: assert property (rmii_mode |-> rxd_oe[3:2] == 2'h0
		&& !collision_oe && !carrier_oe)
		else $error("unused pins driven in reduced mode");
	a_rmii_clk_off: assert property (rmii_mode
		|-> !transmit_clock_out && !receive_clock_out)
		else $error("clock out in reduced mode");
	a_rmii_tx_low: assert property (rmii_mode |-> core_tx.data[3:2] == 2'h0)
		else $error("upper transmit bits passed in reduced mode");
	a_iso_quiet: assert property (core_cfg.isolate[*2] |-> !any_oe)
		else $error("pin driven while isolated");
	a_drive_late: assert property (any_oe |-> age_q >= 4'h8)
		else $error("pin driven before straps captured");

	// Main scenarios reached
	c_unmapped: cover property (pslverr);
	c_rmii_run: cover property (rmii_mode && rxd_oe[0]);
	c_isolated: cover property (core_cfg.isolate && !any_oe);
endmodule : ppm_pin_mux_properties

bind ppm_pin_mux ppm_pin_mux_properties i_ppm_pin_mux_properties (.clk,
	.nrst, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .rxd_oe,
	.receive_valid_oe, .receive_error_oe, .collision_oe, .carrier_oe,
	.receive_clock_out, .transmit_clock_out, .core_tx, .core_cfg, .rmii_mode);
`default_nettype wire

//--- ppm_mac_model.sv
// Reference clock source and MAC transmit side
`timescale 1ns/1ns
`default_nettype none

module ppm_mac_model
	import ppm_pkg::*;
(
	// Mode and word to send
	input  wire logic    mac_rmii,
	input  wire ppm_tx_t tx_word,
	// Pins into the device
	output logic         reference_clock_in,
	output logic         transmit_enable_in,
	output logic [3:0]   txd_in
);
	// free running reference, odd phase to the bench clock
	initial begin
		reference_clock_in = 1'h0;
		transmit_enable_in = 1'h0;
		txd_in = 4'h0;
		#37;
		forever #80 reference_clock_in = ~reference_clock_in;
	end

	// change at the fall so the rise sees settled pins
	always @(negedge reference_clock_in) begin
		transmit_enable_in <= tx_word.enable;
		// Upper pins are unused in reduced mode and left floating high
		txd_in <= mac_rmii ? {2'h3, tx_word.data[1:0]} : tx_word.data;
	end
endmodule : ppm_mac_model
`default_nettype wire

//--- test_phy_pin_function_and_strap_latch.sv
// Bench for the shared pin block
`timescale 1ns/1ns
`default_nettype none

module test_phy_pin_function_and_strap_latch
	import ppm_pkg::*;
;
	// Bus, pins and core side
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0, pull = 0, core_int_event = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, mac_rmii = 0, interrupt_output, rmii_mode;
	logic reference_clock_in, transmit_enable_in, receive_clock_out;
	logic [3:0] txd_in, rxd_i, rxd_o, rxd_oe;
	logic receive_valid_i, receive_valid_o, receive_valid_oe;
	logic receive_error_i, receive_error_o, receive_error_oe;
	logic collision_i, collision_o, collision_oe, transmit_clock_out;
	logic carrier_i, carrier_o, carrier_oe;
	ppm_rx_t core_rx = 0;
	ppm_tx_t core_tx, tx_word = 0;
	ppm_strap_t core_cfg;
	int n_mismatch = 0, check_count = 0;

	always #5 clk = ~clk;

	// Undriven pins settle to their strap resistor
	assign rxd_i = (rxd_oe & rxd_o) | (~rxd_oe & pull[7:4]);
	assign receive_valid_i = receive_valid_oe ? receive_valid_o : pull[3];
	assign receive_error_i = receive_error_oe ? receive_error_o : pull[2];
	assign collision_i = collision_oe ? collision_o : pull[1];
	assign carrier_i = carrier_oe ? carrier_o : pull[0];

	ppm_pin_mux i_ppm_pin_mux (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .reference_clock_in,
		.transmit_enable_in, .txd_in, .rxd_i, .rxd_o, .rxd_oe,
		.receive_valid_i, .receive_valid_o, .receive_valid_oe,
		.receive_error_i, .receive_error_o, .receive_error_oe, .collision_i,
		.collision_o, .collision_oe, .carrier_i, .carrier_o, .carrier_oe,
		.receive_clock_out, .transmit_clock_out, .interrupt_output, .core_rx,
		.core_int_event, .core_tx, .core_cfg, .rmii_mode);
	ppm_mac_model i_ppm_mac_model (.mac_rmii, .tx_word, .reference_clock_in,
		.transmit_enable_in, .txd_in);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One bus transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		chk(32'(n >= 20), 32'h0);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'h0, a, 32'h0, d, e);
		chk(d, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'h1, a, d, x, e);
		chk({31'h0, e}, 32'h0);
	endtask : wr

	// Event pulse, then time for status and pin to follow
	task automatic pulse(input int b, input logic lvl);
		@(posedge clk);
		core_int_event[b] <= 1'h1;
		@(posedge clk);
		core_int_event <= 8'h00;
		repeat (4) @(posedge clk);
		chk({31'h0, interrupt_output}, {31'h0, lvl});
	endtask : pulse

	// Reset with given straps, then traffic both ways
	task automatic run(input logic [7:0] p, input logic r,
		input logic [7:0] st, input logic [7:0] pins, input logic [4:0] tx);
		int t;
		nrst <= 1'h0;
		pull <= p;
		mac_rmii <= r;
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		repeat (20) @(posedge clk);
		rd(8'h70, {24'h0, st});
		chk({23'h0, rmii_mode, core_cfg}, {23'h0, r, st});
		rd(8'h00, {21'h0, p[2], 1'h0, p[4], 8'h0});
		chk({28'h0, rxd_oe}, r ? 32'h3 : 32'hF);
		core_rx <= {4'hA, 1'h0, 1'h1, 1'h1, 1'h1};
		tx_word <= {1'h1, 4'hD};
		repeat (50) @(posedge clk);
		chk({24'h0, rxd_i, receive_valid_i, receive_error_i, collision_i,
			carrier_i}, {24'h0, pins});
		chk({27'h0, core_tx}, {27'h0, tx});
		t = 0;
		repeat (40) begin
			@(posedge clk);
			t += int'(transmit_clock_out !== receive_clock_out ||
				transmit_clock_out === 1'h1);
		end
		chk(32'(t > 0), {31'h0, !r});
	endtask : run

	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		logic [31:0] d;
		logic e;
		run(8'hA9, 1'h0, 8'hA6, 8'hA7, 5'h1D);
		rd(8'h7C, 32'h0);
		wr(8'h6C, 32'h100);
		pulse(1, 1'h1);
		pulse(0, 1'h0);
		rd(8'h6C, 32'h103);
		pulse(2, 1'h1);
		wr(8'h7C, 32'h200);
		pulse(1, 1'h0);
		pulse(0, 1'h1);
		apb(1'h0, 8'h04, 32'h0, d, e);
		chk({e, d[30:0]}, 32'h80000000);
		wr(8'h00, 32'h400);
		repeat (3) @(posedge clk);
		chk({28'h0, rxd_oe}, 32'h0);
		run(8'h52, 1'h1, 8'h51, 8'h6E, 5'h11);
		conclude();
	end

	// Watchdog well past the expected run
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
endmodule : test_phy_pin_function_and_strap_latch
`default_nettype wire
